// >>> rtl/wdpd_map.svh
// Register offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDPD_MAP_SVH
`define WDPD_MAP_SVH
// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define WDPD_ADDR_WDT_CTRL    12'h000
`define WDPD_ADDR_RST_FLAGS   12'h004
`define WDPD_ADDR_STATUS      12'h008
`define WDPD_ADDR_CLK_CTRL    12'h00C
`define WDPD_ADDR_WAKE_EN     12'h010
// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define WDPD_KEY_MSB          7
`define WDPD_KEY_LSB          3
`define WDPD_SEL_MSB          2
`define WDPD_SEL_LSB          0
`define WDPD_KEY_A            5'h0A
`define WDPD_KEY_B            5'h15
`define WDPD_WDT_CTRL_RST     8'h53
`define WDPD_KFRF_BIT         0
`define WDPD_LOW_VOLTAGE_RESET_FLAG_BIT         2
`define WDPD_STAT_PDF_BIT     0
`define WDPD_STAT_TO_BIT      1
`define WDPD_CLK_SLOW_BIT     0
`define WDPD_CLK_FAST_BIT     1
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDPD_KEY_FAULT_DELAY  16
`define WDPD_CNT_W            18
`endif

// >>> rtl/wdpd_pkg.sv
// Types shared by the watchdog and power-down block
package wdpd_pkg;
    typedef enum logic [1:0] {
        WDPD_RUN,
        WDPD_HALT,
        WDPD_KEY_WAIT
    } wdpd_state_t;
endpackage

// >>> rtl/wdpd_top.sv
// Watchdog timer with halt entry, wake-up sources and reset-cause flags
//
// What this block does
// - Halt, fast keep only: stop core, fast on
// - Halt keeps memory, registers and ports
// - Halt sets power-down, clears timeout flag
// - Halt clears watchdog counter, counting continues
// - Wake on port edge, interrupt, or overflow
// - Power-down flag cleared by power-up, clear instr
// - Halt timeout: flags set, PC/SP reset only
// - Per-pin wake enable; resume after halt
// - Masked interrupt wake resumes, service deferred
// - Request pending before halt cannot wake
// - Watchdog runs on slow oscillator, divided
// - Period select picks 2^8 to 2^18
// - Bad key resets after delay, sets flag
// - Key field starts at enabled value
// - Key fault flag cleared only by software
// - Normal timeout: full reset, sets timeout flag
// - Counter cleared by key fault, clear, halt
// - Unimplemented reset-flag bits read zero
// - Halt, no keep bits: sleep, watchdog only
// - Halt, slow keep only: fast off, slow on
// - Halt, both keeps: both clocks on
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "wdpd_map.svh"

module wdpd_top #(
    parameter int PORT_W          = 8,
    parameter int KEY_FAULT_DELAY = `WDPD_KEY_FAULT_DELAY
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [11:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Core side
    input  wire logic              i_halt_instr,
    input  wire logic              i_wdt_clear_instr,
    input  wire logic              i_irq_req,
    input  wire logic              i_irq_enabled,
    input  wire logic              i_stack_full,
    input  wire logic              i_low_voltage_event,
    input  wire logic              i_slow_osc,
    input  wire logic [PORT_W-1:0] i_port_a,
    output logic                   o_core_run,
    output logic                   o_fast_clk_en,
    output logic                   o_slow_clk_en,
    output logic                   o_full_reset,
    output logic                   o_pc_sp_reset,
    output logic                   o_irq_service_ok,
    output logic                   o_power_down_flag,
    output logic                   o_watchdog_timeout_flag
);
    // ------------------------------------------------------------------------
    // Elaboration checks and timing
    // ------------------------------------------------------------------------
    localparam int KD_W = $clog2(KEY_FAULT_DELAY + 1);

    if (PORT_W < 1 || PORT_W > 32) begin
        $error("PORT_W must lie in 1..32");
    end
    if (KEY_FAULT_DELAY < 1) begin
        $error("KEY_FAULT_DELAY must be at least 1");
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]              wdt_ctrl_q;
    logic                    key_fault_reset_flag_q;
    logic                    low_voltage_reset_flag_q;
    logic                    high_osc_idle_keep_q;
    logic                    low_osc_idle_keep_q;
    logic [PORT_W-1:0]       port_a_wake_enable_q;
    logic                    power_down_flag_q;
    logic                    watchdog_timeout_flag_q;
    wdpd_pkg::wdpd_state_t   state_q;
    logic [`WDPD_CNT_W-1:0]  wdt_cnt_q;
    logic [KD_W-1:0]         kd_cnt_q;
    logic                    irq_armed_q;

    // APB strobes; slave answers in the access cycle, zero wait
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    assign wr_en     = i_psel && i_penable && i_pwrite;
    assign rd_en     = i_psel && i_penable && !i_pwrite;
    assign o_pready  = 1'b1;
    assign addr_ok   = (i_paddr == `WDPD_ADDR_WDT_CTRL) || (i_paddr == `WDPD_ADDR_RST_FLAGS)
                    || (i_paddr == `WDPD_ADDR_STATUS) || (i_paddr == `WDPD_ADDR_CLK_CTRL)
                    || (i_paddr == `WDPD_ADDR_WAKE_EN);

    assign o_pslverr = i_psel && i_penable && !addr_ok;

    // ------------------------------------------------------------------------
    // Slow clock: three-stage sampling, rising edge as enable pulse
    // ------------------------------------------------------------------------
    logic [2:0] slow_sync_q;
    logic       slow_tick;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            slow_sync_q <= 3'b000;
        end else begin
            slow_sync_q <= {slow_sync_q[1:0], i_slow_osc};
        end
    end
    assign slow_tick = slow_sync_q[1] && !slow_sync_q[2];

    // Port A sampling; stage 0 read only by stage 1
    logic [PORT_W-1:0] pa_s0_q;
    logic [PORT_W-1:0] pa_s1_q;
    logic [PORT_W-1:0] pa_s2_q;
    logic [PORT_W-1:0] pa_fall;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pa_s0_q <= '1;
            pa_s1_q <= '1;
            pa_s2_q <= '1;
        end else begin
            pa_s0_q <= i_port_a;
            pa_s1_q <= pa_s0_q;
            pa_s2_q <= pa_s1_q;
        end
    end
    assign pa_fall = pa_s2_q & ~pa_s1_q & port_a_wake_enable_q;

    // ------------------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------------------
    logic [4:0] key;
    logic       key_ok;
    logic       halting;
    logic       timeout;
    logic       wake_pin;
    logic       wake_irq;
    logic [4:0] sel_bit;

    assign key     = wdt_ctrl_q[`WDPD_KEY_MSB:`WDPD_KEY_LSB];
    assign key_ok  = (key == `WDPD_KEY_A) || (key == `WDPD_KEY_B);
    assign halting = (state_q == wdpd_pkg::WDPD_RUN) && i_halt_instr;


    // Period select to counter bit index
    always_comb begin
        case (wdt_ctrl_q[`WDPD_SEL_MSB:`WDPD_SEL_LSB])
            3'd0:    sel_bit = 5'd7;
            3'd1:    sel_bit = 5'd9;
            3'd2:    sel_bit = 5'd11;
            3'd3:    sel_bit = 5'd13;
            3'd4:    sel_bit = 5'd14;
            3'd5:    sel_bit = 5'd15;
            3'd6:    sel_bit = 5'd16;
            default: sel_bit = 5'd17;
        endcase
    end

    // Terminal count: all bits up to selected bit set = 2^(sel_bit+1) ticks
    logic [`WDPD_CNT_W-1:0] sel_mask;

    assign sel_mask = `WDPD_CNT_W'((2 << sel_bit) - 1);
    assign timeout  = slow_tick && ((wdt_cnt_q & sel_mask) == sel_mask)
                   && (state_q != wdpd_pkg::WDPD_KEY_WAIT);

    assign wake_pin = |pa_fall;
    // Only a request that rises during halt may wake
    assign wake_irq = i_irq_req && irq_armed_q;

    // ------------------------------------------------------------------------
    // Run / halt / key-fault state machine
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q  <= wdpd_pkg::WDPD_RUN;
            kd_cnt_q <= '0;
        end else begin
            case (state_q)
                wdpd_pkg::WDPD_RUN: begin
                    if (!key_ok) begin
                        state_q  <= wdpd_pkg::WDPD_KEY_WAIT;
                        kd_cnt_q <= '0;
                    end else if (i_halt_instr) begin
                        state_q <= wdpd_pkg::WDPD_HALT;
                    end
                end
                wdpd_pkg::WDPD_HALT: begin
                    if (!key_ok) begin
                        state_q  <= wdpd_pkg::WDPD_KEY_WAIT;
                        kd_cnt_q <= '0;
                    end else if (wake_pin || wake_irq || timeout) begin
                        state_q <= wdpd_pkg::WDPD_RUN;
                    end
                end
                default: begin
                    // Delay counted in slow ticks before the reset fires
                    if (kd_cnt_q == KD_W'(KEY_FAULT_DELAY)) begin
                        state_q <= wdpd_pkg::WDPD_RUN;
                    end else if (slow_tick) begin
                        kd_cnt_q <= kd_cnt_q + 1'b1;
                    end
                end
            endcase
        end
    end

    // Key fault fires its reset at the end of the delay
    logic key_fault_fire;

    assign key_fault_fire = (state_q == wdpd_pkg::WDPD_KEY_WAIT) && (kd_cnt_q == KD_W'(KEY_FAULT_DELAY));

    // Interrupt wake arming: pending-at-halt requests never wake
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_armed_q <= 1'b0;
        end else if (halting) begin
            irq_armed_q <= !i_irq_req;
        end else if (state_q == wdpd_pkg::WDPD_HALT && !i_irq_req) begin
            irq_armed_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wdt_cnt_q <= '0;
        end else if (!key_ok || halting || i_wdt_clear_instr || timeout || key_fault_fire) begin
            wdt_cnt_q <= '0;
        end else if (slow_tick) begin
            wdt_cnt_q <= wdt_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Status flags; set beats clear
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            power_down_flag_q <= 1'b0;
        end else if (halting || (timeout && state_q == wdpd_pkg::WDPD_HALT)) begin
            power_down_flag_q <= 1'b1;
        end else if (i_wdt_clear_instr) begin
            power_down_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            watchdog_timeout_flag_q <= 1'b0;
        end else if (timeout) begin
            watchdog_timeout_flag_q <= 1'b1;
        end else if (halting) begin
            watchdog_timeout_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Software registers; key fault restores the enabled key value
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wdt_ctrl_q <= `WDPD_WDT_CTRL_RST;
        end else if (key_fault_fire) begin
            wdt_ctrl_q <= `WDPD_WDT_CTRL_RST;
        end else if (wr_en && i_paddr == `WDPD_ADDR_WDT_CTRL) begin
            wdt_ctrl_q <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            key_fault_reset_flag_q <= 1'b0;
        end else if (key_fault_fire) begin
            key_fault_reset_flag_q <= 1'b1;
        end else if (wr_en && i_paddr == `WDPD_ADDR_RST_FLAGS && !i_pwdata[`WDPD_KFRF_BIT]) begin
            key_fault_reset_flag_q <= 1'b0;
        end
    end

    // Low-voltage flag is unknown at power-on; zero chosen here
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            low_voltage_reset_flag_q <= 1'b0;
        end else if (i_low_voltage_event) begin
            low_voltage_reset_flag_q <= 1'b1;
        end else if (wr_en && i_paddr == `WDPD_ADDR_RST_FLAGS) begin
            low_voltage_reset_flag_q <= i_pwdata[`WDPD_LOW_VOLTAGE_RESET_FLAG_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            high_osc_idle_keep_q <= 1'b0;
            low_osc_idle_keep_q  <= 1'b0;
        end else if (wr_en && i_paddr == `WDPD_ADDR_CLK_CTRL) begin
            high_osc_idle_keep_q <= i_pwdata[`WDPD_CLK_FAST_BIT];
            low_osc_idle_keep_q  <= i_pwdata[`WDPD_CLK_SLOW_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            port_a_wake_enable_q <= '0;
        end else if (wr_en && i_paddr == `WDPD_ADDR_WAKE_EN) begin
            port_a_wake_enable_q <= i_pwdata[PORT_W-1:0];
        end
    end

    // Read data registered on the access cycle's edge is too late, so mux live
    always_comb begin
        o_prdata = 32'h0000_0000;
        if (rd_en) begin
            if (i_paddr == `WDPD_ADDR_WDT_CTRL) begin
                o_prdata[7:0] = wdt_ctrl_q;
            end else if (i_paddr == `WDPD_ADDR_RST_FLAGS) begin
                o_prdata[`WDPD_KFRF_BIT] = key_fault_reset_flag_q;
                o_prdata[`WDPD_LOW_VOLTAGE_RESET_FLAG_BIT] = low_voltage_reset_flag_q;
            end else if (i_paddr == `WDPD_ADDR_STATUS) begin
                o_prdata[`WDPD_STAT_PDF_BIT] = power_down_flag_q;
                o_prdata[`WDPD_STAT_TO_BIT]  = watchdog_timeout_flag_q;
            end else if (i_paddr == `WDPD_ADDR_CLK_CTRL) begin
                o_prdata[`WDPD_CLK_FAST_BIT] = high_osc_idle_keep_q;
                o_prdata[`WDPD_CLK_SLOW_BIT] = low_osc_idle_keep_q;
            end else if (i_paddr == `WDPD_ADDR_WAKE_EN) begin
                o_prdata[PORT_W-1:0] = port_a_wake_enable_q;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Core-facing outputs, registered
    // ------------------------------------------------------------------------
    logic in_halt;
    assign in_halt = (state_q == wdpd_pkg::WDPD_HALT);

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_core_run       <= 1'b1;
            o_fast_clk_en    <= 1'b1;
            o_slow_clk_en    <= 1'b1;
            o_full_reset     <= 1'b0;
            o_pc_sp_reset    <= 1'b0;
            o_irq_service_ok <= 1'b0;
        end else begin

            // Halt stops the core and drops each clock enable whose keep bit is clear
            o_core_run    <= !in_halt || wake_pin || wake_irq || timeout;
            o_fast_clk_en <= !in_halt || high_osc_idle_keep_q;
            o_slow_clk_en <= !in_halt || low_osc_idle_keep_q;
            o_full_reset  <= (timeout && !in_halt) || key_fault_fire;
            o_pc_sp_reset <= timeout && in_halt;
            o_irq_service_ok <= i_irq_req && i_irq_enabled && !i_stack_full && !in_halt;
        end
    end

    assign o_power_down_flag       = power_down_flag_q;
    assign o_watchdog_timeout_flag = watchdog_timeout_flag_q;
endmodule

// >>> test/wdpd_monitor.sv
// Port-level assertion checker for the watchdog and power-down block
`timescale 1ns/1ps
`include "wdpd_map.svh"
module wdpd_monitor (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        i_halt_instr,
    input wire logic        i_wdt_clear_instr,
    input wire logic        i_irq_req,
    input wire logic        i_irq_enabled,
    input wire logic        i_stack_full,
    input wire logic        o_core_run,
    input wire logic        o_fast_clk_en,
    input wire logic        o_slow_clk_en,
    input wire logic        o_full_reset,
    input wire logic        o_pc_sp_reset,
    input wire logic        o_irq_service_ok,
    input wire logic        o_power_down_flag,
    input wire logic        o_watchdog_timeout_flag
);
    // ------------------------------------------------------------------------
    // Shadow state and properties
    // ------------------------------------------------------------------------
    logic       key_ok_q;
    logic [1:0] keep_q;
    logic       wr;
    assign wr = i_psel && i_penable && i_pwrite;
    // Shadow of key validity and keep bits; halt is refused while a key fault waits
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            key_ok_q <= 1'b1;
            keep_q   <= 2'b00;
        end else begin
            if (wr && i_paddr == `WDPD_ADDR_WDT_CTRL)
                key_ok_q <= i_pwdata[7:3] inside {`WDPD_KEY_A, `WDPD_KEY_B};
            else if (o_full_reset)
                key_ok_q <= 1'b1;
            if (wr && i_paddr == `WDPD_ADDR_CLK_CTRL)
                keep_q <= i_pwdata[1:0];
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_halt_flags: assert property (i_halt_instr && o_core_run && key_ok_q |=> o_power_down_flag && !o_watchdog_timeout_flag)
        else $error("halt left flags wrong");
    a_halt_stops: assert property (i_halt_instr && o_core_run && key_ok_q |-> ##[1:4] !o_core_run)
        else $error("halt did not stop the core");
    a_clear_pdf: assert property (i_wdt_clear_instr && !i_halt_instr |=> !o_power_down_flag)
        else $error("clear left power-down flag set");
    a_idle_clocks: assert property ($fell(o_core_run) |=> o_fast_clk_en == keep_q[1] && o_slow_clk_en == keep_q[0])
        else $error("halt clock enables wrong");
    a_run_clocks: assert property ($rose(o_core_run) |=> o_fast_clk_en && o_slow_clk_en)
        else $error("clocks not restored");
    a_pcsp_flags: assert property ($rose(o_pc_sp_reset) |-> o_power_down_flag && o_watchdog_timeout_flag)
        else $error("halt timeout flags wrong");
    a_pcsp_pulse: assert property (o_pc_sp_reset |=> !o_pc_sp_reset && o_core_run)
        else $error("halt timeout did not resume");
    a_one_reset: assert property (!(o_full_reset && o_pc_sp_reset))
        else $error("both reset kinds at once");
    a_full_pulse: assert property (o_full_reset |=> !o_full_reset)
        else $error("full reset longer than a cycle");
    a_rsvd_zero: assert property (i_psel && i_penable && !i_pwrite && i_paddr == `WDPD_ADDR_RST_FLAGS
        |-> o_prdata[31:3] == '0 && !o_prdata[1])
        else $error("reserved flag bits not zero");
    a_irq_ok: assert property (o_irq_service_ok |-> $past(i_irq_req && i_irq_enabled && !i_stack_full))
        else $error("interrupt serviced while masked");
    c_sleep: cover property (!o_core_run && !o_fast_clk_en && !o_slow_clk_en);
    c_pcsp: cover property (o_pc_sp_reset);
    c_full: cover property (o_full_reset);
    c_irq: cover property (o_irq_service_ok);
endmodule

bind wdpd_top wdpd_monitor u_mon (.*);

// >>> test/wdpd_core_model.sv
// Processor core model issuing halt and watchdog clear instructions
`timescale 1ns/1ps
module wdpd_core_model (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_core_run,
    input  wire logic i_halt_req,
    input  wire logic i_clear_req,
    output logic      o_halt_instr      = 1'b0,
    output logic      o_wdt_clear_instr = 1'b0
);
    // A halted core executes nothing, so requests are dropped while stopped
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_halt_instr      <= 1'b0;
            o_wdt_clear_instr <= 1'b0;
        end else begin
            o_halt_instr      <= i_halt_req && i_core_run;
            o_wdt_clear_instr <= i_clear_req && i_core_run;
        end
    end
endmodule

// >>> test/wdpd_top_bench.sv
// Self-checking bench for the watchdog and power-down block
`timescale 1ns/1ps
`include "wdpd_map.svh"
module wdpd_top_bench;
    // ------------------------------------------------------------------------
    // Stimulus, partner and checks
    // ------------------------------------------------------------------------
    localparam int KFD = 2;
    logic        i_clk = 1'b0, i_reset_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [11:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata, rd;
    logic        o_pready, o_pslverr, err, halt_req = 1'b0, clear_req = 1'b0, i_halt_instr, i_wdt_clear_instr;
    logic        i_irq_req = 1'b0, i_irq_enabled = 1'b0, i_stack_full = 1'b0, i_low_voltage_event = 1'b0;
    logic        i_slow_osc, o_core_run, o_fast_clk_en, o_slow_clk_en, o_full_reset, o_pc_sp_reset;
    logic        o_irq_service_ok, o_power_down_flag, o_watchdog_timeout_flag;
    logic [7:0]  i_port_a = 8'hFF;
    logic [2:0]  sdiv = '0;
    logic [4:0]  key;
    int          mismatches = 0, tests_run = 0, ticks = 0, n, pin;
    wdpd_top #(.PORT_W(8), .KEY_FAULT_DELAY(KFD)) DUT (.*);
    wdpd_core_model u_core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_core_run(o_core_run),
        .i_halt_req(halt_req), .i_clear_req(clear_req),
        .o_halt_instr(i_halt_instr), .o_wdt_clear_instr(i_wdt_clear_instr));
    // Clocks; slow oscillator is eight fast cycles so the samplers see every tick
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) sdiv <= sdiv + 3'h1;
    assign i_slow_osc = sdiv[2];
    always @(posedge i_slow_osc) ticks++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        @(posedge i_clk);
        while (o_pready !== 1'b1) @(posedge i_clk);
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string msg);
        apb(1'b0, a, '0);
        chk(rd, exp, msg);
    endtask
    // One instruction from the core: halt or watchdog clear
    task automatic instr(input logic h);
        @(posedge i_clk);
        halt_req  <= h;
        clear_req <= !h;
        @(posedge i_clk);
        halt_req  <= 1'b0;
        clear_req <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic wrun(input logic v);
        for (n = 0; n < 40 && o_core_run !== v; n++) @(posedge i_clk);
        @(posedge i_clk);
    endtask
    function automatic int period(input int s);
        int e [8] = '{8, 10, 12, 14, 15, 16, 17, 18};
        return 1 << e[s];
    endfunction
    task automatic stop_test;
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge i_clk);
        mismatches++;
        stop_test;
    end
    initial begin
        void'($urandom(32'h1302_f324));
        repeat (5) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rchk(`WDPD_ADDR_WDT_CTRL, 32'h0000_0053, "ctrl reset");
        rchk(`WDPD_ADDR_RST_FLAGS, '0, "flags reset");
        rchk(`WDPD_ADDR_STATUS, '0, "status reset");
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        chk(err, 1'b1, "unmapped write");
        apb(1'b1, `WDPD_ADDR_RST_FLAGS, $urandom() | 32'h0000_0005);
        rchk(`WDPD_ADDR_RST_FLAGS, 32'h0000_0004, "reserved bits");
        apb(1'b1, `WDPD_ADDR_RST_FLAGS, '0);
        // Every keep-bit combination, woken by an enabled pin only
        for (int k = 0; k < 4; k++) begin
            pin = $urandom_range(7, 0);
            apb(1'b1, `WDPD_ADDR_CLK_CTRL, k);
            apb(1'b1, `WDPD_ADDR_WAKE_EN, 32'h1 << pin);
            instr(1'b1);
            wrun(1'b0);
            chk({o_core_run, o_fast_clk_en, o_slow_clk_en, o_power_down_flag, o_watchdog_timeout_flag},
                {1'b0, k[1:0], 2'b10}, "halt mode");
            i_port_a[(pin + 1) % 8] <= 1'b0;
            repeat (8) @(posedge i_clk);
            chk(o_core_run, 1'b0, "disabled pin woke");
            i_port_a[pin] <= 1'b0;
            wrun(1'b1);
            chk(o_core_run, 1'b1, "pin wake");
            i_port_a <= 8'hFF;
            instr(1'b0);
            chk(o_power_down_flag, 1'b0, "clear instr");
        end
        rchk(`WDPD_ADDR_WDT_CTRL, 32'h0000_0053, "ctrl kept over halt");
        // Interrupt wake: a request pending at halt must not wake
        apb(1'b1, `WDPD_ADDR_CLK_CTRL, '0);
        i_irq_req <= 1'b1;
        instr(1'b1);
        repeat (20) @(posedge i_clk);
        chk(o_core_run, 1'b0, "pending irq woke");
        i_irq_req <= 1'b0;
        repeat (4) @(posedge i_clk);
        i_irq_req <= 1'b1;
        wrun(1'b1);
        chk({o_core_run, o_irq_service_ok}, 2'b10, "masked irq wake");
        i_irq_enabled <= 1'b1;
        i_stack_full  <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk(o_irq_service_ok, 1'b0, "stack full");
        i_stack_full <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(o_irq_service_ok, 1'b1, "irq serviced");
        i_irq_req     <= 1'b0;
        i_irq_enabled <= 1'b0;
        // Timeout length in run for the short periods
        for (int s = 0; s < 3; s++) begin
            key = $urandom_range(1, 0) ? `WDPD_KEY_B : `WDPD_KEY_A;
            apb(1'b1, `WDPD_ADDR_WDT_CTRL, {24'h0, key, s[2:0]});
            instr(1'b0);
            ticks = 0;
            for (n = 0; n < period(s) * 8 + 100 && o_full_reset !== 1'b1; n++) @(posedge i_clk);
            chk(ticks >= period(s) - 2 && ticks <= period(s) + 2, 1'b1, "run timeout");
            chk(o_watchdog_timeout_flag, 1'b1, "timeout flag");
        end
        // Halt restarts the count; timeout in halt resets only PC/SP and resumes the core
        apb(1'b1, `WDPD_ADDR_WDT_CTRL, {24'h0, `WDPD_KEY_A, 3'h0});
        instr(1'b0);
        ticks = 0;
        while (ticks < 200) @(posedge i_clk);
        instr(1'b1);
        ticks = 0;
        for (n = 0; n < 2400 && o_pc_sp_reset !== 1'b1; n++) @(posedge i_clk);
        chk(ticks >= 254 && ticks <= 258, 1'b1, "halt count");
        chk({o_full_reset, o_power_down_flag, o_watchdog_timeout_flag}, 3'b011, "halt timeout");
        wrun(1'b1);
        chk(o_core_run, 1'b1, "resume after timeout");
        // Bad key: reset after the delay, flag cleared only by software
        key = $urandom_range(31, 0);
        if (key == `WDPD_KEY_A || key == `WDPD_KEY_B) key = 5'h00;
        apb(1'b1, `WDPD_ADDR_WDT_CTRL, {24'h0, key, 3'h3});
        ticks = 0;
        for (n = 0; n < KFD * 8 + 100 && o_full_reset !== 1'b1; n++) @(posedge i_clk);
        chk(ticks >= KFD - 1 && ticks <= KFD + 2, 1'b1, "key fault delay");
        rchk(`WDPD_ADDR_WDT_CTRL, 32'h0000_0053, "ctrl restored");
        rchk(`WDPD_ADDR_RST_FLAGS, 32'h0000_0001, "key fault flag");
        instr(1'b0);
        apb(1'b1, `WDPD_ADDR_RST_FLAGS, 32'h0000_0001);
        rchk(`WDPD_ADDR_RST_FLAGS, 32'h0000_0001, "flag sticky");
        apb(1'b1, `WDPD_ADDR_RST_FLAGS, '0);
        rchk(`WDPD_ADDR_RST_FLAGS, '0, "flag cleared");
        stop_test;
    end
endmodule
